// [hdl/pwd_top.sv]
// Prefetchable window decode top: config port plus routing decision.
// Assumes software programs the window before use; one core clock.
`timescale 1ns/10ps
module pwd_top (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire pwd_pkg::pwd_cfg_req_t cfg,
   input  wire pwd_pkg::pwd_mem_req_t mem,
   output logic [31:0]                cfg_rdata,
   output logic                       cfg_rvalid,
   output logic                       route_valid,
   output logic                       route_to_port
);
   logic [31:0]          rdata_d;
   pwd_pkg::pwd_window_t win;
   logic                 hit;

   pwd_regs u_regs (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cfg     (cfg),
      .rdata_d (rdata_d),
      .win     (win)
   );

   pwd_match u_match (
      .addr (mem.addr),
      .win  (win),
      .hit  (hit)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_rdata  <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg.rd;
         cfg_rdata  <= cfg.rd ? rdata_d : 32'h0000_0000;
      end
   end

   // Routing result one cycle after the request; software must program first (R09)
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         route_valid   <= 1'b0;
         route_to_port <= 1'b0;
      end else begin
         route_valid   <= mem.valid;
         route_to_port <= mem.valid && hit; // R01
      end
   end

   AST_ROUTE_HIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mem.valid |=> route_to_port == $past(hit)) // R01
      else $error("Routing does not follow window match");
   AST_NO_ROUTE_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !mem.valid |=> !route_to_port) // R01
      else $error("Route without request");
   AST_LIMIT_NIBBLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg.rd && cfg.addr == pwd_pkg::OFS_BASE_LOW)
      |=> cfg_rdata[19:16] == 4'h1 && cfg_rdata[3:0] == 4'h1) // R03
      else $error("64-bit indication wrong");
   AST_CAP_PTR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg.rd && cfg.addr == pwd_pkg::OFS_CAP_PTR) |=> cfg_rdata == 32'h0000_0088) // R10
      else $error("Capability pointer wrong");
   AST_LIMIT_TOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (mem.valid && mem.addr[39:20] == {win.limit_39_32, win.limit_31_20}
       && {win.base_39_32, win.base_31_20} <= {win.limit_39_32, win.limit_31_20})
      |=> route_to_port) // R04
      else $error("Limit block not fully covered");
   AST_BASE_BOTTOM: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (mem.valid && mem.addr[39:20] == {win.base_39_32, win.base_31_20}
       && {win.base_39_32, win.base_31_20} <= {win.limit_39_32, win.limit_31_20})
      |=> route_to_port) // R05
      else $error("Base block not fully covered");
   AST_EMPTY_WINDOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ({win.base_39_32, win.base_31_20} > {win.limit_39_32, win.limit_31_20})
      |=> !route_to_port) // R12
      else $error("Inverted window matched");
   AST_UPPER_BASE_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg.wr && cfg.addr == pwd_pkg::OFS_BASE_HIGH && cfg.be[0])
      |=> win.base_39_32 == $past(cfg.wdata[7:0])) // R06 R08
      else $error("Upper base write lost");
   AST_UPPER_LIMIT_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg.wr && cfg.addr == pwd_pkg::OFS_LIMIT_HIGH && cfg.be[0])
      |=> win.limit_39_32 == $past(cfg.wdata[7:0])) // R07 R08
      else $error("Upper limit write lost");
   AST_LOW_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg.wr && cfg.addr == pwd_pkg::OFS_BASE_LOW && cfg.be == 4'hf)
      |=> win.limit_31_20 == $past(cfg.wdata[31:20])
          && win.base_31_20 == $past(cfg.wdata[15:4])) // R02 R11
      else $error("Low base or limit write lost");

   COV_HIT: cover property (@(posedge sys_clk) disable iff (!rst_n) route_to_port);
   COV_MISS: cover property (@(posedge sys_clk) disable iff (!rst_n)
      route_valid && !route_to_port);
   COV_PROGRAM: cover property (@(posedge sys_clk) disable iff (!rst_n)
      cfg.wr && cfg.addr == pwd_pkg::OFS_LIMIT_HIGH);
endmodule

// [hdl/pwd_pkg.sv]
// Package for the prefetchable window decode: offsets, fields, resets, carriers.
// Assumes a config-space access port with byte enables, one core clock.
// Behaviour
// (R01) Forward processor memory access when base <= address <= limit.
// (R02) Limit-low bits 15:4 writable, give limit A[31:20], reset 000h.
// (R03) Limit-low bits 3:0 read-only 1h, upper limit held at 2Ch.
// (R04) Limit compare treats A[19:0] as all ones, 1MB block top.
// (R05) Base compare treats A[19:0] as zero, 1MB aligned start.
// (R06) Upper-base is 32-bit writable, gives base A[63:32], reset zero.
// (R07) Upper-limit is 32-bit writable, gives limit A[63:32], reset zero.
// (R08) Low 8 bits of each upper register give A[39:32] of decode.
// (R09) Software programs base and limit before relying on routing.
// (R10) Capability pointer is read-only and returns 88h.
// (R11) Base-low bits 15:4 give base A[31:20], bits 3:0 read 1h.
// (R12) Base above limit matches nothing; no access routed.
package pwd_pkg;
   localparam logic [7:0]  OFS_BASE_LOW    = 8'h24;
   localparam logic [7:0]  OFS_LIMIT_LOW   = 8'h26;
   localparam logic [7:0]  OFS_BASE_HIGH   = 8'h28;
   localparam logic [7:0]  OFS_LIMIT_HIGH  = 8'h2c;
   localparam logic [7:0]  OFS_CAP_PTR     = 8'h34;
   localparam logic [11:0] RST_BASE_ADDR   = 12'hfff;
   localparam logic [11:0] RST_LIMIT_ADDR  = 12'h000;
   localparam logic [3:0]  ADDR64_CODE     = 4'h1;
   localparam logic [31:0] RST_UPPER       = 32'h0000_0000;
   localparam logic [7:0]  CAP_PTR_VALUE   = 8'h88;
   localparam int          LOW_FIELD_LSB   = 4;
   localparam int          BLOCK_BITS      = 20;
   localparam int          DEC_ADDR_W      = 40;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pwd_cfg_req_t;

   typedef struct packed {
      logic        valid;
      logic [39:0] addr;
   } pwd_mem_req_t;

   typedef struct packed {
      logic [11:0] base_31_20;
      logic [11:0] limit_31_20;
      logic [7:0]  base_39_32;
      logic [7:0]  limit_39_32;
   } pwd_window_t;
endpackage

// [hdl/pwd_regs.sv]
// Window configuration registers, config-space read and write port.
// Assumes dword-aligned addr and byte enables per lane, one core clock.
`timescale 1ns/10ps
module pwd_regs (
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire pwd_pkg::pwd_cfg_req_t cfg,
   output logic [31:0]             rdata_d,
   output pwd_pkg::pwd_window_t    win
);
   logic [11:0] base_addr_31_20_q;
   logic [11:0] limit_addr_31_20_q;
   logic [31:0] base_addr_63_32_q;
   logic [31:0] limit_addr_63_32_q;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [31:0] low_old;
   logic [31:0] low_new;
   assign low_old = {limit_addr_31_20_q, pwd_pkg::ADDR64_CODE,
                     base_addr_31_20_q, pwd_pkg::ADDR64_CODE};
   assign low_new = merge(low_old, cfg.wdata, cfg.be);

   // Base and limit dword at 24h; low nibbles stay hardwired
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base_addr_31_20_q  <= pwd_pkg::RST_BASE_ADDR;
         limit_addr_31_20_q <= pwd_pkg::RST_LIMIT_ADDR; // R02
      end else if (cfg.wr && cfg.addr == pwd_pkg::OFS_BASE_LOW) begin
         base_addr_31_20_q  <= low_new[15:4];  // R11
         limit_addr_31_20_q <= low_new[31:20]; // R02
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base_addr_63_32_q <= pwd_pkg::RST_UPPER;
      end else if (cfg.wr && cfg.addr == pwd_pkg::OFS_BASE_HIGH) begin
         base_addr_63_32_q <= merge(base_addr_63_32_q, cfg.wdata, cfg.be); // R06
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         limit_addr_63_32_q <= pwd_pkg::RST_UPPER;
      end else if (cfg.wr && cfg.addr == pwd_pkg::OFS_LIMIT_HIGH) begin
         limit_addr_63_32_q <= merge(limit_addr_63_32_q, cfg.wdata, cfg.be); // R07
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (cfg.addr == pwd_pkg::OFS_BASE_LOW) begin
         rdata_d = low_old; // R03
      end else if (cfg.addr == pwd_pkg::OFS_BASE_HIGH) begin
         rdata_d = base_addr_63_32_q;
      end else if (cfg.addr == pwd_pkg::OFS_LIMIT_HIGH) begin
         rdata_d = limit_addr_63_32_q;
      end else if (cfg.addr == pwd_pkg::OFS_CAP_PTR) begin
         rdata_d = {24'h00_0000, pwd_pkg::CAP_PTR_VALUE}; // R10
      end
   end

   // Only A[39:32] decode; upper bits are stored but ignored
   assign win.base_31_20  = base_addr_31_20_q;
   assign win.limit_31_20 = limit_addr_31_20_q;
   assign win.base_39_32  = base_addr_63_32_q[7:0];  // R08
   assign win.limit_39_32 = limit_addr_63_32_q[7:0]; // R08
endmodule

// [hdl/pwd_match.sv]
// Pure compare of a 40-bit address against the programmed window.
// Assumes window fields stable while compared.
`timescale 1ns/10ps
module pwd_match (
   input  wire logic [39:0]          addr,
   input  wire pwd_pkg::pwd_window_t win,
   output logic                      hit
);
   logic [39:0] lo;
   logic [39:0] hi;
   assign lo = {win.base_39_32, win.base_31_20, 20'h0_0000};   // R05
   assign hi = {win.limit_39_32, win.limit_31_20, 20'hf_ffff}; // R04
   // Base above limit gives an empty range by itself
   assign hit = (addr >= lo) && (addr <= hi); // R01 R12
endmodule

// [tb/pwd_host.sv]
// Processor side partner: issues one memory access, collects routing.
// Assumes the decode answers exactly one cycle after the access.
`timescale 1ns/10ps
module pwd_host (
   input  wire logic             sys_clk,
   output pwd_pkg::pwd_mem_req_t mem,
   input  wire logic             route_valid,
   input  wire logic             route_to_port
);
   initial mem = '0;
   task automatic access(input logic [39:0] a, input int gap, output logic v, output logic h);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      mem = '{valid: 1'b1, addr: a};
      @(posedge sys_clk);
      #1;
      // Released bus, no stale address left
      mem = '{valid: 1'b0, addr: ~a};
      v = route_valid;
      h = route_to_port;
   endtask
endmodule

// [tb/tb_top.sv]
// Bench for pwd_top: config port against a register model, routing
// decisions against a window model. Assumes one-cycle answers.
`timescale 1ns/10ps
module tb_top;
   logic                  sys_clk;
   logic                  rst_n;
   pwd_pkg::pwd_cfg_req_t cfg;
   pwd_pkg::pwd_mem_req_t mem;
   logic [31:0]           cfg_rdata;
   logic                  cfg_rvalid;
   logic                  route_valid;
   logic                  route_to_port;
   logic [31:0]           r24, r28, r2c, v;
   logic [39:0]           lo, hi;
   logic [39:0]           a [5];
   logic                  rv, hit;
   int                    errors, tests_run;
   pwd_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .mem(mem),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .route_valid(route_valid),
      .route_to_port(route_to_port));
   pwd_host host (.sys_clk(sys_clk), .mem(mem), .route_valid(route_valid),
      .route_to_port(route_to_port));
   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         if (be[b]) o[8*b +: 8] = n[8*b +: 8];
      end
      return o;
   endfunction
   task check(input logic [39:0] s, input logic [39:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task cfg_op(input logic w, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      #1;
      cfg = '{wr: w, rd: !w, addr: ad, be: be, wdata: d};
      @(posedge sys_clk);
      #1;
      cfg = '0;
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] e);
      cfg_op(1'b0, ad, 4'h0, 32'h0);
      check(cfg_rvalid, 1'b1);
      check(cfg_rdata, e);
   endtask
   task wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
      cfg_op(1'b1, ad, be, d);
      // Read-only nibbles stay at the 64-bit code
      if (ad == 8'h24) r24 = (merge(r24, d, be) & 32'hfff0_fff0) | 32'h0001_0001;
      if (ad == 8'h28) r28 = merge(r28, d, be);
      if (ad == 8'h2c) r2c = merge(r2c, d, be);
   endtask
   task end_sim;
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      rst_n = 1'b0;
      cfg = '0;
      errors = 0;
      tests_run = 0;
      r24 = 32'h0001_fff1;
      r28 = 32'h0;
      r2c = 32'h0;
      void'($urandom(32'h383822e2));
      repeat (5) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      rd(8'h24, r24);
      rd(8'h28, r28);
      rd(8'h2c, r2c);
      wr(8'h34, 4'hf, 32'hffff_ffff);
      wr(8'h30, 4'hf, 32'hffff_ffff);
      rd(8'h34, 32'h0000_0088);
      rd(8'h30, 32'h0);
      for (int i = 0; i < 5; i++) begin
         // Window fully programmed before any access relies on it
         wr(8'h24, (i == 1) ? 4'h3 : 4'hf, $urandom);
         v = $urandom;
         wr(8'h28, (i == 2) ? 4'h5 : 4'hf, v);
         wr(8'h2c, 4'hf, v + i - 2);
         rd(8'h24, r24);
         rd(8'h28, r28);
         rd(8'h2c, r2c);
         lo = {r28[7:0], r24[15:4], 20'h00000};
         hi = {r2c[7:0], r24[31:20], 20'hfffff};
         a = '{lo, lo - 40'h1, hi, hi + 40'h1, 40'({$urandom, $urandom})};
         foreach (a[j]) begin
            host.access(a[j], $urandom_range(2), rv, hit);
            check(rv, 1'b1);
            check(hit, a[j] >= lo && a[j] <= hi);
         end
      end
      // Mid-run reset must bring back every default after random writes
      @(posedge sys_clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      check(route_valid, 1'b0);
      check(route_to_port, 1'b0);
      rst_n = 1'b1;
      r24 = 32'h0001_fff1;
      r28 = 32'h0;
      r2c = 32'h0;
      rd(8'h24, r24);
      rd(8'h28, r28);
      rd(8'h2c, r2c);
      // Default window is inverted, so nothing may be routed
      host.access(40'h00_0000_0000, 0, rv, hit);
      check(rv, 1'b1);
      check(hit, 1'b0);
      end_sim;
   end
endmodule
